//--- hw/sreg_top.sv
`timescale 1ns/100ps
`include "sreg_cfg.svh"
// Notes on behaviour
// RQ1: any of overrun, framing or parity flags raises the receive-error request.
// RQ2: receive-error request never triggers the transfer controller; CPU path only.
// RQ3: error request alone only possible with receive-full request disabled.
// RQ4: software sets receive enable and error-only select both to one.
// RQ5: error-only select blocks every receive-full request, so no DMA transfers.
// RQ6: error request holds while enable set and any error flag remains.
module sreg_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // channel status flags, from outside this clock domain
    input wire logic overrun_error_flag,
    input wire logic framing_error_flag,
    input wire logic parity_error_flag,
    input wire logic receive_data_full,
    // requests to cpu interrupt controller and transfer engines
    output logic receive_error_request,
    output logic receive_full_request,
    output logic full_transfer_trigger,
    output logic irq
);
    import sreg_pkg::*;

    typedef struct packed {
        sreg_flags_t sync1;
        sreg_flags_t sync2;
        logic receive_irq_enable;
        logic error_only_irq_select;
        logic [`SREG_EV_W-1:0] ev_stat;
        logic [`SREG_EV_W-1:0] ev_mask;
        sreg_req_t req_q;
        logic irq;
        sreg_apb_rsp_t rsp;
    } sreg_state_t;

    sreg_state_t state;
    sreg_state_t next_state;
    sreg_req_t gate_req;
    sreg_apb_req_t bus;
    logic [`SREG_EV_W-1:0] ev_set;
    logic [`SREG_EV_W-1:0] ev_clr;
    logic wr_acc;
    logic rd_setup;

    assign bus = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    sreg_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .receive_irq_enable(state.receive_irq_enable),
        .error_only_irq_select(state.error_only_irq_select),
        .flags(state.sync2),
        .req(gate_req)
    );

    always_comb begin
        next_state = state;
        // two-flop synchroniser; only sync2 feeds logic
        next_state.sync1 = '{overrun_error_flag, framing_error_flag, parity_error_flag, receive_data_full};
        next_state.sync2 = state.sync1;
        next_state.req_q = gate_req;
        // rising edges of the requests are the sticky events
        ev_set = '0;
        ev_set[`SREG_EV_ERR_BIT] = gate_req.receive_error_request & ~state.req_q.receive_error_request;
        ev_set[`SREG_EV_FULL_BIT] = gate_req.receive_full_request & ~state.req_q.receive_full_request;
        wr_acc = bus.psel & bus.penable & bus.pwrite;
        rd_setup = bus.psel & ~bus.penable & ~bus.pwrite;
        ev_clr = '0;
        // zero-wait slave: access phase always completes
        next_state.rsp.pready = bus.psel & ~bus.penable;
        next_state.rsp.pslverr = 1'b0;
        if (wr_acc) begin
            if (bus.paddr == `SREG_CTRL_OFF) begin
                // RQ4 honoured by software: both bits set gives error-only irqs
                next_state.receive_irq_enable = bus.pwdata[`SREG_CTRL_RX_EN_BIT];
                next_state.error_only_irq_select = bus.pwdata[`SREG_CTRL_ERR_ONLY_BIT];
            end else if (bus.paddr == `SREG_IRQ_STAT_OFF) begin
                ev_clr = bus.pwdata[`SREG_EV_W-1:0];
            end else if (bus.paddr == `SREG_IRQ_MASK_OFF) begin
                next_state.ev_mask = bus.pwdata[`SREG_EV_W-1:0];
            end else if (bus.paddr != `SREG_STAT_OFF) begin
                next_state.rsp.pslverr = 1'b0;
            end
        end
        // set beats clear in the same cycle
        next_state.ev_stat = (state.ev_stat & ~ev_clr) | ev_set;
        next_state.irq = |(next_state.ev_stat & state.ev_mask);
        // read data prepared in setup, stands through access
        if (rd_setup) begin
            next_state.rsp.prdata = 32'h0;
            if (bus.paddr == `SREG_CTRL_OFF) begin
                next_state.rsp.prdata[`SREG_CTRL_RX_EN_BIT] = state.receive_irq_enable;
                next_state.rsp.prdata[`SREG_CTRL_ERR_ONLY_BIT] = state.error_only_irq_select;
            end else if (bus.paddr == `SREG_STAT_OFF) begin
                next_state.rsp.prdata[`SREG_STAT_OVR_BIT] = state.sync2.overrun_error_flag;
                next_state.rsp.prdata[`SREG_STAT_FRM_BIT] = state.sync2.framing_error_flag;
                next_state.rsp.prdata[`SREG_STAT_PAR_BIT] = state.sync2.parity_error_flag;
                next_state.rsp.prdata[`SREG_STAT_ERR_REQ_BIT] = gate_req.receive_error_request;
                next_state.rsp.prdata[`SREG_STAT_FULL_REQ_BIT] = gate_req.receive_full_request;
            end else if (bus.paddr == `SREG_IRQ_STAT_OFF) begin
                next_state.rsp.prdata[`SREG_EV_W-1:0] = state.ev_stat;
            end else if (bus.paddr == `SREG_IRQ_MASK_OFF) begin
                next_state.rsp.prdata[`SREG_EV_W-1:0] = state.ev_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pready = state.rsp.pready;
    assign pslverr = state.rsp.pslverr;
    assign prdata = state.rsp.prdata;
    // error request goes to the cpu only; transfer trigger never carries it
    assign receive_error_request = gate_req.receive_error_request; // RQ2
    assign receive_full_request = gate_req.receive_full_request; // RQ5
    assign full_transfer_trigger = gate_req.full_transfer_trigger;
    assign irq = state.irq;
endmodule // sreg_top

//--- hw/sreg_cfg.svh
`ifndef SREG_CFG_SVH
`define SREG_CFG_SVH

// register byte offsets
`define SREG_CTRL_OFF 12'h000
`define SREG_STAT_OFF 12'h004
`define SREG_IRQ_STAT_OFF 12'h008
`define SREG_IRQ_MASK_OFF 12'h00C

// control field positions
`define SREG_CTRL_RX_EN_BIT 0
`define SREG_CTRL_ERR_ONLY_BIT 1

// status field positions (flags and request levels)
`define SREG_STAT_OVR_BIT 0
`define SREG_STAT_FRM_BIT 1
`define SREG_STAT_PAR_BIT 2
`define SREG_STAT_ERR_REQ_BIT 3
`define SREG_STAT_FULL_REQ_BIT 4

// sticky event bits
`define SREG_EV_ERR_BIT 0
`define SREG_EV_FULL_BIT 1
`define SREG_EV_W 2

// reset values
`define SREG_CTRL_RST 2'h0
`define SREG_MASK_RST 2'h0

`endif

//--- hw/sreg_pkg.sv
package sreg_pkg;
    typedef struct packed {
        logic overrun_error_flag;
        logic framing_error_flag;
        logic parity_error_flag;
        logic receive_data_full;
    } sreg_flags_t;

    typedef struct packed {
        logic receive_error_request;
        logic receive_full_request;
        logic full_transfer_trigger;
    } sreg_req_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sreg_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sreg_apb_rsp_t;
endpackage

//--- hw/sreg_gate.sv
`timescale 1ns/100ps
`include "sreg_cfg.svh"
module sreg_gate (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enables and flags
    input wire logic receive_irq_enable,
    input wire logic error_only_irq_select,
    input wire sreg_pkg::sreg_flags_t flags,
    // requests
    output sreg_pkg::sreg_req_t req
);
    import sreg_pkg::*;

    typedef struct packed {
        sreg_req_t req;
    } sreg_gate_state_t;

    sreg_gate_state_t state;
    sreg_gate_state_t next_state;
    logic any_err;

    always_comb begin
        next_state = state;
        any_err = flags.overrun_error_flag | flags.framing_error_flag | flags.parity_error_flag;
        // level request, held while enabled and any error flag stays set
        next_state.req.receive_error_request = receive_irq_enable & any_err; // RQ1 RQ6
        // full request gone entirely in error-only mode
        next_state.req.receive_full_request = receive_irq_enable & ~error_only_irq_select
            & flags.receive_data_full; // RQ3 RQ5
        // transfer engines see only the data-full flag, not gated by receive enable, never the error one
        next_state.req.full_transfer_trigger = ~error_only_irq_select & flags.receive_data_full; // RQ2 RQ5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign req = state.req;
endmodule // sreg_gate

//--- tb/sreg_dma_model.sv
`timescale 1ns/100ps
module sreg_dma_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // trigger from the gating block
    input wire logic full_transfer_trigger,
    // transfers started
    output int moved
);
    logic last;
    // one transfer per rising trigger: a held level is still the same data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            moved <= 0;
        end else begin
            last <= full_transfer_trigger;
            if (full_transfer_trigger && !last) moved <= moved + 1;
        end
    end
endmodule // sreg_dma_model

//--- tb/sreg_checker.sv
`timescale 1ns/100ps
`include "sreg_cfg.svh"
module sreg_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // flags
    input wire logic overrun_error_flag,
    input wire logic framing_error_flag,
    input wire logic parity_error_flag,
    input wire logic receive_data_full,
    // requests
    input wire logic receive_error_request,
    input wire logic receive_full_request,
    input wire logic full_transfer_trigger
);
    logic [1:0] ctrl_q;
    logic [1:0] age;
    logic any_err;
    assign any_err = overrun_error_flag | framing_error_flag | parity_error_flag;
    // shadow of the control word; age hides the sync pipe after each reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 2'h0;
            age <= 2'h0;
        end else begin
            if (psel && penable && pwrite && paddr == `SREG_CTRL_OFF) ctrl_q <= pwdata[1:0];
            if (age != 2'h3) age <= age + 2'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_level: assert property (age == 2'h3 |->
        receive_error_request == ($past(ctrl_q[0]) && $past(any_err, 3))) else $error("error request wrong");
    a_full_gate: assert property (age == 2'h3 |->
        receive_full_request == ($past(ctrl_q) == 2'h1 && $past(receive_data_full, 3))) else $error("full request wrong");
    a_trig_source: assert property (age == 2'h3 |->
        full_transfer_trigger == (!$past(ctrl_q[1]) && $past(receive_data_full, 3))) else $error("trigger wrong");
    a_err_alone: assert property (receive_error_request && $past(ctrl_q[1]) |->
        !receive_full_request && !full_transfer_trigger) else $error("error not alone");
    a_err_no_trigger: assert property ($rose(receive_error_request) && !$past(receive_data_full, 3) |->
        !full_transfer_trigger) else $error("error drove trigger");
    c_err_only: cover property (receive_error_request && ctrl_q[1]);
    c_full: cover property (receive_full_request);
    c_trig: cover property ($rose(full_transfer_trigger));
endmodule // sreg_checker
bind sreg_top sreg_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .overrun_error_flag(overrun_error_flag),
    .framing_error_flag(framing_error_flag), .parity_error_flag(parity_error_flag),
    .receive_data_full(receive_data_full), .receive_error_request(receive_error_request),
    .receive_full_request(receive_full_request), .full_transfer_trigger(full_transfer_trigger));

//--- tb/sreg_top_bench.sv
`timescale 1ns/100ps
`include "sreg_cfg.svh"
module sreg_top_bench;
    import sreg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err_req, full_req, trig, irq, slv;
    logic [3:0] fl = 4'h0;
    int n_fail = 0, compares = 0, moved;
    always #25 pclk = ~pclk;
    sreg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .overrun_error_flag(fl[3]), .framing_error_flag(fl[2]), .parity_error_flag(fl[1]),
        .receive_data_full(fl[0]), .receive_error_request(err_req), .receive_full_request(full_req),
        .full_transfer_trigger(trig), .irq(irq));
    sreg_dma_model dma_u (.pclk(pclk), .presetn(presetn), .full_transfer_trigger(trig), .moved(moved));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken at the very edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({err_req, full_req, trig, irq}, 4'h0);
        apb(1'b0, `SREG_IRQ_MASK_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `SREG_IRQ_MASK_OFF, 32'h3);
        apb(1'b1, `SREG_CTRL_OFF, 32'h1);
        for (int i = 1; i < 4; i++) begin
            fl <= 4'h1 << i;
            settle;
            chk({err_req, trig, irq}, 3'h5);
            apb(1'b0, `SREG_STAT_OFF, 32'h0);
            chk(rd, 32'h8 | (32'h8 >> i));
            apb(1'b1, `SREG_IRQ_STAT_OFF, 32'h1);
            settle;
            chk({err_req, irq}, 2'h2);
            fl <= 4'h0;
            settle;
            chk(err_req, 1'b0);
        end
        fl <= 4'h1;
        settle;
        chk({full_req, trig, irq}, 3'h7);
        apb(1'b0, `SREG_IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h2);
        fl <= 4'h9;
        apb(1'b1, `SREG_CTRL_OFF, 32'h3);
        settle;
        chk({err_req, full_req, trig}, 3'h4);
        apb(1'b1, `SREG_IRQ_STAT_OFF, 32'h3);
        apb(1'b1, `SREG_IRQ_MASK_OFF, 32'h0);
        fl <= 4'h0;
        settle;
        fl <= 4'h2;
        settle;
        chk({err_req, irq}, 2'h2);
        apb(1'b0, `SREG_IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        // unmapped read: no error response, ready gone after the access
        chk({slv, pready}, 2'h0);
        chk(moved, 32'h1);
        stop_test;
    end
endmodule // sreg_top_bench
